// *** inc/psr_pkg.sv ***
// Constants and types for the preset speed decoder and relay one selector
package psr_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_COND = 12'h008;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_SRC_LSB = 0;
   localparam int unsigned CTRL_CODE_LSB = 8;
   localparam int unsigned STAT_IDX_LSB = 0;
   localparam int unsigned STAT_RELAY_BIT = 4;
   localparam int unsigned STAT_ACTIVE_BIT = 5;

   // ---------------------------------------------------------------
   // Preset source selection
   // ---------------------------------------------------------------
   localparam int unsigned SRC_W = 4;
   localparam logic [3:0] SRC_NONE = 4'h0;
   localparam logic [3:0] SRC_IN123 = 4'h9;
   localparam logic [3:0] SRC_IN345 = 4'ha;
   localparam int unsigned IDX_W = 3;
   localparam logic [2:0] IDX_NONE = 3'h0;
   localparam int unsigned NUM_IN = 5;
   localparam int unsigned HIGH_IN_BASE = 2;

   // ---------------------------------------------------------------
   // Relay one content codes
   // ---------------------------------------------------------------
   localparam int unsigned CODE_W = 5;
   localparam int unsigned NUM_COND = 21;
   typedef enum logic [4:0] {
      RLY_NOT_SEL = 5'b00000,
      RLY_READY = 5'b00001,
      RLY_RUN = 5'b00010,
      RLY_FAULT_INV = 5'b00011,
      RLY_FAULT = 5'b00100,
      RLY_ALARM = 5'b00101,
      RLY_REVERSED = 5'b00110,
      RLY_SUP1_HIGH = 5'b00111,
      RLY_SUP1_LOW = 5'b01000,
      RLY_SUP2_HIGH = 5'b01001,
      RLY_SUP2_LOW = 5'b01010,
      RLY_FREQ_MATCH = 5'b01011,
      RLY_FAULT_RST = 5'b01100,
      RLY_FAULT_ALARM = 5'b01101,
      RLY_EXT_CTRL = 5'b01110,
      RLY_SECOND_EXTERNAL_LOCATION = 5'b01111,
      RLY_PRESET = 5'b10000,
      RLY_REF_LOSS = 5'b10001,
      RLY_OVERCURRENT = 5'b10010,
      RLY_OVERVOLTAGE = 5'b10011,
      RLY_OVERTEMP = 5'b10100
   } psr_relay_code_t;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] RST_SRC = SRC_NONE;
   localparam logic [4:0] RST_CODE = 5'h00;
   localparam logic RST_RELAY = 1'b0;

endpackage

// *** rtl/psr_preset_decode.sv ***
// Three-input preset speed index decoder
`timescale 1ns/1ps
module psr_preset_decode (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Source option and inputs
   input wire logic [psr_pkg::SRC_W-1:0] source,
   input wire logic [psr_pkg::NUM_IN-1:0] inputs,
   // Decoded index
   output logic [psr_pkg::IDX_W-1:0] index_r
);

   logic [psr_pkg::IDX_W-1:0] bits_low;
   logic [psr_pkg::IDX_W-1:0] bits_high;
   logic [psr_pkg::IDX_W-1:0] index_nxt;

   // ---------------------------------------------------------------
   // Bit gathering, first input weighs least
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < psr_pkg::IDX_W; i++) begin : g_bit
         assign bits_low[i] = inputs[i];
         assign bits_high[i] = inputs[i + psr_pkg::HIGH_IN_BASE];
      end
   endgenerate

   // Source choice, other options give no preset
   always_comb begin
      case (source)
         psr_pkg::SRC_IN123: index_nxt = bits_low;
         psr_pkg::SRC_IN345: index_nxt = bits_high;
         default: index_nxt = psr_pkg::IDX_NONE;
      endcase
   end

   // Registered index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_r <= psr_pkg::IDX_NONE;
      end else begin
         index_r <= index_nxt;
      end
   end

endmodule

// *** rtl/psr_relay_select.sv ***
// Relay one content selector
`timescale 1ns/1ps
module psr_relay_select (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Selection and conditions
   input wire logic [psr_pkg::CODE_W-1:0] code,
   input wire logic [psr_pkg::NUM_COND-1:0] cond,
   // Relay drive
   output logic relay_r
);

   logic relay_nxt;

   // Pick one condition, unknown codes stay off
   always_comb begin
      if (code < psr_pkg::CODE_W'(psr_pkg::NUM_COND)) begin
         relay_nxt = cond[code];
      end else begin
         relay_nxt = psr_pkg::RST_RELAY;
      end
   end

   // Registered relay drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_r <= psr_pkg::RST_RELAY;
      end else begin
         relay_r <= relay_nxt;
      end
   end

endmodule

// *** rtl/psr_top.sv ***
// Preset speed decode and relay one selection with APB registers
//
// Behaviour
// - Three inputs form binary preset index, first input least significant; zero means none.
// - Source option 10 decodes inputs three, four, five the same way.
// - Source option 9 decodes inputs one, two, three as the index.
// - Relay content code picks one condition; relay follows it one clock later.
// - Code 0 keeps relay one always off.
// - Code 1 on while ready, run enabled, no fault, supply in range.
// - Code 2 on while the motor is running.
// - Code 3 on with power present, off upon fault trip.
// - Code 4 on while any fault is active.
// - Code 5 on while any alarm is active.
// - Code 6 on while the motor turns in reverse.
// - Code 7 on while first supervised quantity above upper limit.
// - Code 8 on while first supervised quantity below lower limit.
// - Code 9 on while second supervised quantity above upper limit.
// - Code 10 on while second supervised quantity below lower limit.
// - Code 11 on while output frequency equals reference.
// - Code 12 on while in a fault awaiting automatic reset.
// - Code 13 on while a fault or an alarm exists.
// - Code 14 on while external control location is selected.
// - Code 15 on while second external location is selected.
// - Code 16 on while any preset speed is selected.
// - Code 17 on while reference or active control location is lost.
// - Codes 18, 19, 20 on for overcurrent, overvoltage, converter overtemperature.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module psr_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [psr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Digital control inputs
   input wire logic digital_input_one,
   input wire logic digital_input_two,
   input wire logic digital_input_three,
   input wire logic digital_input_four,
   input wire logic digital_input_five,
   // Drive conditions
   input wire logic drive_ready,
   input wire logic run_enable,
   input wire logic supply_in_range,
   input wire logic running,
   input wire logic power_present,
   input wire logic fault_active,
   input wire logic alarm_active,
   input wire logic reverse_rotation,
   input wire logic first_supervision_high,
   input wire logic first_supervision_low,
   input wire logic second_supervision_high,
   input wire logic second_supervision_low,
   input wire logic frequency_matched,
   input wire logic fault_autoreset_pending,
   input wire logic external_location_active,
   input wire logic second_external_location,
   input wire logic reference_lost,
   input wire logic overcurrent,
   input wire logic overvoltage,
   input wire logic converter_overtemperature,
   // Outputs
   output logic [psr_pkg::IDX_W-1:0] preset_index,
   output logic relay_one_drive
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [psr_pkg::SRC_W-1:0] src_r;
   logic [psr_pkg::CODE_W-1:0] code_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic err_nxt;
   logic setup_phase;
   logic wr_take;
   logic [psr_pkg::NUM_IN-1:0] din;
   logic [psr_pkg::NUM_COND-1:0] cond;
   logic [psr_pkg::IDX_W-1:0] index_w;
   logic relay_w;
   logic preset_active;

   // ---------------------------------------------------------------
   // Input gathering
   // ---------------------------------------------------------------
   assign din = {digital_input_five, digital_input_four, digital_input_three,
                 digital_input_two, digital_input_one};
   assign preset_active = (index_w != psr_pkg::IDX_NONE);

   // Condition vector indexed by relay code
   always_comb begin
      cond = '0;
      cond[psr_pkg::RLY_NOT_SEL] = 1'b0;
      cond[psr_pkg::RLY_READY] = drive_ready & run_enable & ~fault_active & supply_in_range;
      cond[psr_pkg::RLY_RUN] = running;
      cond[psr_pkg::RLY_FAULT_INV] = power_present & ~fault_active;
      cond[psr_pkg::RLY_FAULT] = fault_active;
      cond[psr_pkg::RLY_ALARM] = alarm_active;
      cond[psr_pkg::RLY_REVERSED] = reverse_rotation;
      cond[psr_pkg::RLY_SUP1_HIGH] = first_supervision_high;
      cond[psr_pkg::RLY_SUP1_LOW] = first_supervision_low;
      cond[psr_pkg::RLY_SUP2_HIGH] = second_supervision_high;
      cond[psr_pkg::RLY_SUP2_LOW] = second_supervision_low;
      cond[psr_pkg::RLY_FREQ_MATCH] = frequency_matched;
      cond[psr_pkg::RLY_FAULT_RST] = fault_active & fault_autoreset_pending;
      cond[psr_pkg::RLY_FAULT_ALARM] = fault_active | alarm_active;
      cond[psr_pkg::RLY_EXT_CTRL] = external_location_active;
      cond[psr_pkg::RLY_SECOND_EXTERNAL_LOCATION] = second_external_location;
      cond[psr_pkg::RLY_PRESET] = preset_active;
      cond[psr_pkg::RLY_REF_LOSS] = reference_lost;
      cond[psr_pkg::RLY_OVERCURRENT] = overcurrent;
      cond[psr_pkg::RLY_OVERVOLTAGE] = overvoltage;
      cond[psr_pkg::RLY_OVERTEMP] = converter_overtemperature;
   end

   // ---------------------------------------------------------------
   // Datapath blocks
   // ---------------------------------------------------------------
   psr_preset_decode u_decode (
      .pclk(pclk),
      .presetn(presetn),
      .source(src_r),
      .inputs(din),
      .index_r(index_w)
   );

   psr_relay_select u_relay (
      .pclk(pclk),
      .presetn(presetn),
      .code(code_r),
      .cond(cond),
      .relay_r(relay_w)
   );

   assign preset_index = index_w;
   assign relay_one_drive = relay_w;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign setup_phase = psel & ~penable;
   assign wr_take = psel & penable & pready_r & pwrite;

   // Read mux and address check, sampled in setup
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         psr_pkg::OFF_CTRL: begin
            rdata_nxt[psr_pkg::CTRL_SRC_LSB +: psr_pkg::SRC_W] = src_r;
            rdata_nxt[psr_pkg::CTRL_CODE_LSB +: psr_pkg::CODE_W] = code_r;
         end
         psr_pkg::OFF_STATUS: begin
            rdata_nxt[psr_pkg::STAT_IDX_LSB +: psr_pkg::IDX_W] = index_w;
            rdata_nxt[psr_pkg::STAT_RELAY_BIT] = relay_w;
            rdata_nxt[psr_pkg::STAT_ACTIVE_BIT] = preset_active;
         end
         psr_pkg::OFF_COND: begin
            rdata_nxt[psr_pkg::NUM_COND-1:0] = cond;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   // One wait-free access phase per transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup_phase;
         pslverr_r <= setup_phase & err_nxt;
         prdata_r <= (setup_phase & ~pwrite) ? rdata_nxt : 32'h0000_0000;
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   // Control register, written at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_r <= psr_pkg::RST_SRC;
         code_r <= psr_pkg::RST_CODE;
      end else if (wr_take && paddr == psr_pkg::OFF_CTRL) begin
         src_r <= pwdata[psr_pkg::CTRL_SRC_LSB +: psr_pkg::SRC_W];
         code_r <= pwdata[psr_pkg::CTRL_CODE_LSB +: psr_pkg::CODE_W];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_not_sel_off;
      @(posedge pclk) disable iff (!presetn)
      $past(code_r) == psr_pkg::RLY_NOT_SEL |-> !relay_one_drive;
   endproperty
   a_not_sel_off: assert property (p_not_sel_off) else $error("relay on with code 0");

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_READY |=>
         relay_one_drive == $past(drive_ready & run_enable & ~fault_active & supply_in_range);
   endproperty
   a_ready: assert property (p_ready) else $error("ready relay mismatch");

   property p_run;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_RUN && running |=> relay_one_drive;
   endproperty
   a_run: assert property (p_run) else $error("run relay not on");

   property p_fault_inv;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_FAULT_INV && power_present && $rose(fault_active) |=> !relay_one_drive;
   endproperty
   a_fault_inv: assert property (p_fault_inv) else $error("inverted fault relay stayed on");

   property p_fault;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_FAULT |=> relay_one_drive == $past(fault_active);
   endproperty
   a_fault: assert property (p_fault) else $error("fault relay mismatch");

   property p_fault_alarm;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_FAULT_ALARM && !fault_active && !alarm_active |=> !relay_one_drive;
   endproperty
   a_fault_alarm: assert property (p_fault_alarm) else $error("fault or alarm relay on idle");

   property p_overtemp;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_OVERTEMP |=> relay_one_drive == $past(converter_overtemperature);
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemperature relay mismatch");

   property p_idx_low;
      @(posedge pclk) disable iff (!presetn)
      src_r == psr_pkg::SRC_IN123 |=>
         preset_index == $past({digital_input_three, digital_input_two, digital_input_one});
   endproperty
   a_idx_low: assert property (p_idx_low) else $error("preset index from inputs 1-3 wrong");

   property p_idx_high;
      @(posedge pclk) disable iff (!presetn)
      src_r == psr_pkg::SRC_IN345 |=>
         preset_index == $past({digital_input_five, digital_input_four, digital_input_three});
   endproperty
   a_idx_high: assert property (p_idx_high) else $error("preset index from inputs 3-5 wrong");

   property p_preset_relay;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_PRESET && $stable(code_r) && preset_index != psr_pkg::IDX_NONE
         |=> relay_one_drive;
   endproperty
   a_preset_relay: assert property (p_preset_relay) else $error("preset relay not on");

   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

   property p_apb_write;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == psr_pkg::OFF_CTRL
         |=> code_r == $past(pwdata[psr_pkg::CTRL_CODE_LSB +: psr_pkg::CODE_W]);
   endproperty
   a_apb_write: assert property (p_apb_write) else $error("control write not stored");

   property p_alarm;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_ALARM |=> relay_one_drive == $past(alarm_active);
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm relay mismatch");

   property p_reversed;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_REVERSED |=> relay_one_drive == $past(reverse_rotation);
   endproperty
   a_reversed: assert property (p_reversed) else $error("reverse relay mismatch");

   property p_sup1_high;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_SUP1_HIGH |=> relay_one_drive == $past(first_supervision_high);
   endproperty
   a_sup1_high: assert property (p_sup1_high) else $error("first upper limit relay mismatch");

   property p_sup1_low;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_SUP1_LOW |=> relay_one_drive == $past(first_supervision_low);
   endproperty
   a_sup1_low: assert property (p_sup1_low) else $error("first lower limit relay mismatch");

   property p_sup2_high;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_SUP2_HIGH |=> relay_one_drive == $past(second_supervision_high);
   endproperty
   a_sup2_high: assert property (p_sup2_high) else $error("second upper limit relay mismatch");

   property p_sup2_low;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_SUP2_LOW |=> relay_one_drive == $past(second_supervision_low);
   endproperty
   a_sup2_low: assert property (p_sup2_low) else $error("second lower limit relay mismatch");

   property p_freq_match;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_FREQ_MATCH |=> relay_one_drive == $past(frequency_matched);
   endproperty
   a_freq_match: assert property (p_freq_match) else $error("frequency match relay mismatch");

   property p_fault_rst;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_FAULT_RST |=> relay_one_drive == $past(fault_active & fault_autoreset_pending);
   endproperty
   a_fault_rst: assert property (p_fault_rst) else $error("auto reset fault relay mismatch");

   property p_ext_ctrl;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_EXT_CTRL |=> relay_one_drive == $past(external_location_active);
   endproperty
   a_ext_ctrl: assert property (p_ext_ctrl) else $error("external control relay mismatch");

   property p_second_external_location;
      @(posedge pclk) disable iff (!presetn)
      code_r == psr_pkg::RLY_SECOND_EXTERNAL_LOCATION |=> relay_one_drive == $past(second_external_location);
   endproperty
   a_second_external_location: assert property (p_second_external_location) else $error("second location relay mismatch");

endmodule

// *** test/psr_io_model.sv ***
// Model of the switches and drive controller feeding the selection block
`timescale 1ns/1ps
module psr_io_model (
   // Clock
   input wire logic pclk,
   // Requested contact levels and pace
   input wire logic [24:0] req,
   input wire logic slow,
   // Levels at the block pins: [19:0] conditions, [24:20] digital inputs one..five
   output logic [24:0] pins
);
   logic [24:0] stage_r = 25'h0000000;
   logic [24:0] pins_r = 25'h0000000;

   // Contacts settle one clock after a request, or two when slow
   always @(posedge pclk) begin
      stage_r <= req;
      pins_r <= slow ? stage_r : req;
   end

   assign pins = pins_r;
endmodule

// *** test/psr_top_tb.sv ***
// Self-checking testbench for the preset decoder and relay one selector
`timescale 1ns/1ps
module psr_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [psr_pkg::ADDR_W-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [24:0] req = 25'h0000000;
   logic slow = 1'b0;
   logic [24:0] pins;
   logic [2:0] preset_index;
   logic relay_one_drive;
   int fails = 0;
   int num_checks = 0;

   // -------------------------------------------------------------
   // Clock, partner and design
   // -------------------------------------------------------------
   initial begin
      forever #20 pclk = ~pclk;
   end

   psr_io_model u_io (.pclk(pclk), .req(req), .slow(slow), .pins(pins));

   psr_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .digital_input_one(pins[20]), .digital_input_two(pins[21]), .digital_input_three(pins[22]),
      .digital_input_four(pins[23]), .digital_input_five(pins[24]),
      .drive_ready(pins[0]), .run_enable(pins[1]), .supply_in_range(pins[2]), .running(pins[3]),
      .power_present(pins[4]), .fault_active(pins[5]), .alarm_active(pins[6]),
      .reverse_rotation(pins[7]), .first_supervision_high(pins[8]), .first_supervision_low(pins[9]),
      .second_supervision_high(pins[10]), .second_supervision_low(pins[11]),
      .frequency_matched(pins[12]), .fault_autoreset_pending(pins[13]),
      .external_location_active(pins[14]), .second_external_location(pins[15]),
      .reference_lost(pins[16]), .overcurrent(pins[17]), .overvoltage(pins[18]),
      .converter_overtemperature(pins[19]), .preset_index(preset_index),
      .relay_one_drive(relay_one_drive)
   );

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
      chk({31'h0, e}, {31'h0, exp_err}, "write response");
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic e;
      apb(1'b0, a, 32'h00000000, rd, e);
      chk(rd, exp, "read data");
      chk({31'h0, e}, {31'h0, exp_err}, "read response");
   endtask

   // Expected relay level for a code and a set of pin levels
   function automatic logic exp_relay(input int code, input logic [24:0] r);
      case (code)
         1: return r[0] & r[1] & r[2] & ~r[5];
         2: return r[3];
         3: return r[4] & ~r[5];
         4: return r[5];
         5: return r[6];
         6: return r[7];
         7: return r[8];
         8: return r[9];
         9: return r[10];
         10: return r[11];
         11: return r[12];
         12: return r[5] & r[13];
         13: return r[5] | r[6];
         14: return r[14];
         15: return r[15];
         16: return |r[22:20];
         17: return r[16];
         18: return r[17];
         19: return r[18];
         20: return r[19];
         default: return 1'b0;
      endcase
   endfunction

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Outputs cleared in reset with every input high, then release and register reads
   task automatic t_reset();
      @(negedge pclk);
      chk({29'h0, preset_index}, 32'h0, "index at reset");
      chk({31'h0, relay_one_drive}, 32'h0, "relay at reset");
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) begin
         @(negedge pclk);
         chk({28'h0, relay_one_drive, preset_index}, 32'h0, "outputs after release");
      end
      rdchk(psr_pkg::OFF_CTRL, 32'h0, 1'b0);
      rdchk(psr_pkg::OFF_STATUS, 32'h0, 1'b0);
   endtask

   // Unmapped place and read-only register
   task automatic t_bus();
      wr(psr_pkg::OFF_CTRL, 32'h0000_0209, 1'b0);
      wr(12'h00c, 32'h0000_1f0f, 1'b1);
      rdchk(12'h00c, 32'h0, 1'b1);
      wr(psr_pkg::OFF_STATUS, 32'hffff_ffff, 1'b0);
      rdchk(psr_pkg::OFF_CTRL, 32'h0000_0209, 1'b0);
   endtask

   // Every index pattern for both sources, with noise on the unused inputs
   task automatic t_preset();
      logic [2:0] v;
      logic [2:0] e;
      for (int s = 0; s < 3; s++) begin
         wr(psr_pkg::OFF_CTRL, (s == 0) ? 32'h9 : (s == 1) ? 32'ha : 32'h5, 1'b0);
         for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            e = (s == 2) ? 3'h0 : v;
            @(posedge pclk);
            req <= (s == 1) ? {v, ~v[1:0], 20'h0} : (s == 0) ? {~v[1:0], v, 20'h0} : {5'h1f, 20'h0};
            repeat (5) @(posedge pclk);
            @(negedge pclk);
            chk({29'h0, preset_index}, {29'h0, e}, "preset index");
            rdchk(psr_pkg::OFF_STATUS, {26'h0, e != 3'h0, 2'b00, e}, 1'b0);
         end
      end
   endtask

   // Each code against quiet, busy, single-condition and single-gap inputs
   task automatic t_relay();
      logic [24:0] v;
      logic [31:0] cv;
      for (int c = 0; c < 22; c++) begin
         wr(psr_pkg::OFF_CTRL, 32'(c << 8) | 32'h9, 1'b0);
         for (int i = 0; i < 52; i++) begin
            v = (i < 25) ? 25'h1 << i : (i < 50) ? ~(25'h1 << (i - 25)) : (i == 50) ? 25'h0 : '1;
            @(posedge pclk);
            req <= v;
            repeat (5) @(posedge pclk);
            @(negedge pclk);
            chk({31'h0, relay_one_drive}, {31'h0, exp_relay(c, v)}, "relay");
            rdchk(psr_pkg::OFF_STATUS, {26'h0, |v[22:20], exp_relay(c, v), 1'b0, v[22:20]}, 1'b0);
            if (c == 0) begin
               cv = 32'h0;
               for (int n = 1; n < 21; n++) cv[n] = exp_relay(n, v);
               rdchk(psr_pkg::OFF_COND, cv, 1'b0);
            end
         end
      end
   endtask

   // Reset in mid-run with the relay energised
   task automatic t_reset_again();
      wr(psr_pkg::OFF_CTRL, 32'h0000_0209, 1'b0);
      @(posedge pclk);
      req <= '1;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, relay_one_drive}, 32'h1, "relay before reset");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      t_reset();
   endtask

   // -------------------------------------------------------------
   // Run control
   // -------------------------------------------------------------
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      req <= '1;
      repeat (2) @(posedge pclk);
      t_reset();
      t_bus();
      slow <= 1'b1;
      t_preset();
      slow <= 1'b0;
      t_relay();
      t_reset_again();
      final_report();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 60000);
      fails++;
      final_report();
   end
endmodule
